/* File: acp_pkg.sv */
// shared constants and types for the active clamp pwm control block
package acp_pkg;
  localparam int unsigned ACP_CLK_HZ = 20000000;
  localparam int unsigned ACP_FILT_NS = 2000;
  // least time rounds up to whole cycles
  localparam int unsigned ACP_FILT_CYC = (ACP_FILT_NS * (ACP_CLK_HZ / 1000000) + 999) / 1000;
  localparam int unsigned ACP_CNT_W = 8;
  localparam logic [ACP_CNT_W-1:0] ACP_FILT_LAST = ACP_CNT_W'(ACP_FILT_CYC - 1);
  localparam int unsigned ACP_DT_W = 8;
  localparam int unsigned ACP_NGATE = 4;
  localparam int unsigned ACP_G_MAIN = 0;
  localparam int unsigned ACP_G_CLAMP = 1;
  localparam int unsigned ACP_G_FWD = 2;
  localparam int unsigned ACP_G_FREE = 3;
  localparam logic [ACP_DT_W-1:0] ACP_DT_ZERO = 8'h00;
  localparam logic [ACP_DT_W-1:0] ACP_DT_ONE = 8'h01;
  typedef enum logic [1:0] {
    ACP_SS_IDLE,
    ACP_SS_START,
    ACP_SS_STOP,
    ACP_SS_DUMP
  } acp_ss_t;
endpackage : acp_pkg

/* File: acp_gate_if.sv */
// gate request and dead time bundle between controller and delay stages
`timescale 1ns/100ps
interface acp_gate_if;
  logic [acp_pkg::ACP_NGATE-1:0] want;
  logic [acp_pkg::ACP_NGATE-1:0] force_en;
  logic [acp_pkg::ACP_NGATE-1:0] force_val;
  logic [acp_pkg::ACP_NGATE*acp_pkg::ACP_DT_W-1:0] dt_on;
  logic [acp_pkg::ACP_NGATE*acp_pkg::ACP_DT_W-1:0] dt_off;
  logic [acp_pkg::ACP_NGATE-1:0] gate;
  modport ctrl (output want, output force_en, output force_val, output dt_on, output dt_off,
    input gate);
  modport dly (input want, input force_en, input force_val, input dt_on, input dt_off,
    output gate);
endinterface : acp_gate_if

/* File: acp_deadtime.sv */
// per-gate turn-on and turn-off dead time generator with fault override
`timescale 1ns/100ps
module acp_deadtime (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  acp_gate_if.dly gif
);
  genvar g;
  generate
    for (g = 0; g < acp_pkg::ACP_NGATE; g++)
    begin : g_gate
      logic [acp_pkg::ACP_DT_W-1:0] cnt_q;
      logic [acp_pkg::ACP_DT_W-1:0] cnt_d;
      logic gate_q;
      logic gate_d;
      wire logic [acp_pkg::ACP_DT_W-1:0] dly_w = gif.want[g] ?
        gif.dt_on[g*acp_pkg::ACP_DT_W +: acp_pkg::ACP_DT_W] :
        gif.dt_off[g*acp_pkg::ACP_DT_W +: acp_pkg::ACP_DT_W];
      wire logic differ_w = gif.want[g] != gate_q;
      wire logic expired_w = cnt_q >= dly_w;
      // fault force bypasses the counter entirely
      assign gate_d = gif.force_en[g] ? gif.force_val[g] :
        ((differ_w && expired_w) ? gif.want[g] : gate_q);
      assign cnt_d = (gif.force_en[g] || !differ_w || expired_w) ? acp_pkg::ACP_DT_ZERO :
        cnt_q + acp_pkg::ACP_DT_ONE;
      always_ff @(posedge sys_clk_i or negedge rst_b_i)
      begin
        if (!rst_b_i)
        begin
          gate_q <= 1'b0;
          cnt_q <= acp_pkg::ACP_DT_ZERO;
        end
        else
        begin
          gate_q <= gate_d;
          cnt_q <= cnt_d;
        end
      end
      assign gif.gate[g] = gate_q;
      a_force_follows: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        gif.force_en[g] |=> gate_q == $past(gif.force_val[g]))
        else $error("forced gate level not applied");
      a_zero_dt_passes: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (!gif.force_en[g] && differ_w && dly_w == acp_pkg::ACP_DT_ZERO)
          |=> gate_q == $past(gif.want[g]))
        else $error("zero dead time did not pass through");
    end
  endgenerate
endmodule : acp_deadtime

/* File: acp_uv_filter.sv */
// glitch filter: output sets only after input holds for the filter time, clears as soon as input drops
`timescale 1ns/100ps
module acp_uv_filter (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic raw_i,
  output logic flag_o
);
  logic [acp_pkg::ACP_CNT_W-1:0] cnt_q;
  logic flag_q;
  wire logic hold_w = raw_i && !flag_q;
  wire logic done_w = cnt_q >= acp_pkg::ACP_FILT_LAST;
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      cnt_q <= '0;
      flag_q <= 1'b0;
    end
    else
    begin
      cnt_q <= (hold_w && !done_w) ? cnt_q + 1'b1 : '0;
      // clears as soon as the comparator drops
      flag_q <= raw_i && (flag_q || done_w);
    end
  end
  assign flag_o = flag_q;
  a_short_pulse: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    $rose(flag_q) |-> $past(raw_i, 1) && $past(raw_i, 2))
    else $error("fault flag set by a short pulse");
  a_clear_drop: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    !raw_i |=> !flag_q)
    else $error("fault flag held after comparator dropped");
endmodule : acp_uv_filter

/* File: acp_ctrl.sv */
`timescale 1ns/100ps
module acp_ctrl (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic vref_uv_raw_i,
  input wire logic supply_uv_raw_i,
  input wire logic line_uv_raw_i,
  input wire logic thermal_shutdown_flag_i,
  input wire logic ramp_lv_low_i,
  input wire logic ramp_lv_high_i,
  input wire logic res_open_i,
  input wire logic pulse_oc_cmp_i,
  input wire logic hiccup_oc_cmp_i,
  input wire logic pwm_cmp_i,
  input wire logic zero_duty_hi_i,
  input wire logic zero_duty_lo_i,
  input wire logic ss_restart_i,
  input wire logic ss_at_ref_i,
  input wire logic ss_below_fb_i,
  input wire logic osc_clk_i,
  input wire logic maxduty_i,
  input wire logic sync_i,
  input wire logic master_i,
  input wire logic [31:0] dt_on_i,
  input wire logic [31:0] dt_off_i,
  output logic main_gate_o,
  output logic clamp_gate_o,
  output logic forward_rect_gate_o,
  output logic freewheel_rect_gate_o,
  output logic master_clock_out_o,
  output logic sync_clock_o,
  output logic pulse_sense_pulldown_o,
  output logic hiccup_sense_pulldown_o,
  output logic line_hyst_src_o,
  output logic ss_charge_o,
  output logic ss_cc_discharge_o,
  output logic ss_dump_o,
  output logic ramp_precharge_o,
  output logic ref_sel_softstart_o,
  output logic pulse_overcurrent_flag_o,
  output logic hiccup_overcurrent_flag_o,
  output logic zero_duty_flag_o,
  output logic ramp_low_voltage_flag_o,
  output logic fault_o
);
  // two-flop synchronisers for all asynchronous comparator inputs
  localparam int unsigned NSYNC = 17;
  wire logic [NSYNC-1:0] raw_w = {sync_i, maxduty_i, osc_clk_i, ss_below_fb_i, ss_at_ref_i,
    ss_restart_i, zero_duty_lo_i, zero_duty_hi_i, pwm_cmp_i, hiccup_oc_cmp_i, pulse_oc_cmp_i,
    res_open_i, ramp_lv_high_i, ramp_lv_low_i, thermal_shutdown_flag_i, line_uv_raw_i,
    supply_uv_raw_i};
  logic [NSYNC-1:0] s1_q;
  logic [NSYNC-1:0] s2_q;
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      s1_q <= '0;
      s2_q <= '0;
    end
    else
    begin
      s1_q <= raw_w;
      s2_q <= s1_q;
    end
  end
  wire logic sup_uv_s = s2_q[0];
  wire logic line_uv_s = s2_q[1];
  wire logic tsd_s = s2_q[2];
  wire logic lv_low_s = s2_q[3];
  wire logic lv_high_s = s2_q[4];
  wire logic open_s = s2_q[5];
  wire logic poc_s = s2_q[6];
  wire logic hoc_s = s2_q[7];
  wire logic pwm_s = s2_q[8];
  wire logic zd_hi_s = s2_q[9];
  wire logic zd_lo_s = s2_q[10];
  wire logic restart_s = s2_q[11];
  wire logic at_ref_s = s2_q[12];
  wire logic ss_low_s = s2_q[13];
  wire logic osc_s = s2_q[14];
  wire logic maxd_s = s2_q[15];
  wire logic sync_s = s2_q[16];
  logic vref_uv_raw_s1_q;
  logic vref_uv_raw_s2_q;
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      vref_uv_raw_s1_q <= 1'b0;
      vref_uv_raw_s2_q <= 1'b0;
    end
    else
    begin
      vref_uv_raw_s1_q <= vref_uv_raw_i;
      vref_uv_raw_s2_q <= vref_uv_raw_s1_q;
    end
  end

  logic sup_uv_w;
  logic vref_uv_w;
  acp_uv_filter u_sup_filt (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .raw_i(sup_uv_s),
    .flag_o(sup_uv_w)
  );
  acp_uv_filter u_vref_filt (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .raw_i(vref_uv_raw_s2_q),
    .flag_o(vref_uv_w)
  );

  // ramp low-voltage flag: set at lower threshold, clear at higher
  logic lvp_q;
  wire logic lvp_d = lv_low_s ? 1'b1 : (lv_high_s ? 1'b0 : lvp_q);

  // switching clock: master uses own oscillator, slave the sync rising edge
  logic sync_d1_q;
  wire logic sync_rise_w = sync_s && !sync_d1_q;
  wire logic cyc_clk_w = master_i ? osc_s : sync_rise_w;
  logic cyc_d1_q;
  wire logic cyc_start_w = cyc_clk_w && !cyc_d1_q;

  // soft-start sequencing
  wire logic hard_w = sup_uv_w || vref_uv_w || lvp_q || open_s;
  wire logic soft_w = line_uv_s || tsd_s || hoc_s;
  acp_pkg::acp_ss_t ss_q;
  acp_pkg::acp_ss_t ss_d;
  always_comb
  begin
    ss_d = ss_q;
    case (ss_q)
      acp_pkg::ACP_SS_IDLE: ss_d = acp_pkg::ACP_SS_START;
      acp_pkg::ACP_SS_START: if (soft_w) ss_d = acp_pkg::ACP_SS_STOP;
      // latched until the restart level is reached and the fault is gone
      acp_pkg::ACP_SS_STOP: if (restart_s && !soft_w) ss_d = acp_pkg::ACP_SS_START;
      acp_pkg::ACP_SS_DUMP: if (!hard_w) ss_d = acp_pkg::ACP_SS_STOP;
      default: ss_d = acp_pkg::ACP_SS_DUMP;
    endcase
    if (hard_w)
    begin
      ss_d = acp_pkg::ACP_SS_DUMP;
    end
  end
  wire logic any_fault_w = hard_w || soft_w || ss_q != acp_pkg::ACP_SS_START;

  // zero duty flag with hysteresis: set at lower threshold after resume
  logic zd_q;
  wire logic zd_d = zd_q ? zd_hi_s : zd_lo_s;

  // pwm set-reset latch, reset dominant
  logic latch_q;
  wire logic latch_rst_w = pwm_s || poc_s || maxd_s || zd_q || any_fault_w;
  wire logic latch_d = latch_rst_w ? 1'b0 : (cyc_start_w ? 1'b1 : latch_q);

  // pulse overcurrent held until next cycle
  logic poc_q;
  wire logic poc_d = poc_s ? 1'b1 : (cyc_start_w ? 1'b0 : poc_q);

  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      lvp_q <= 1'b0;
      sync_d1_q <= 1'b0;
      cyc_d1_q <= 1'b0;
      ss_q <= acp_pkg::ACP_SS_IDLE;
      zd_q <= 1'b0;
      latch_q <= 1'b0;
      poc_q <= 1'b0;
    end
    else
    begin
      lvp_q <= lvp_d;
      sync_d1_q <= sync_s;
      cyc_d1_q <= cyc_clk_w;
      ss_q <= ss_d;
      zd_q <= zd_d;
      latch_q <= latch_d;
      poc_q <= poc_d;
    end
  end

  // gate requests and fault forcing
  acp_gate_if gif ();
  wire logic gate_kill_w = hard_w;
  assign gif.want = {!latch_q, latch_q, !latch_q, latch_q};
  assign gif.force_en = {acp_pkg::ACP_NGATE{gate_kill_w || poc_q}};
  assign gif.force_val = {!gate_kill_w, 1'b0, 1'b0, 1'b0};
  assign gif.dt_on = dt_on_i;
  assign gif.dt_off = dt_off_i;
  acp_deadtime u_dt (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .gif(gif.dly)
  );

  // registered outputs
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      master_clock_out_o <= 1'b0;
      sync_clock_o <= 1'b0;
      line_hyst_src_o <= 1'b0;
      ss_charge_o <= 1'b0;
      ss_cc_discharge_o <= 1'b0;
      ss_dump_o <= 1'b1;
      ramp_precharge_o <= 1'b0;
      ref_sel_softstart_o <= 1'b1;
      pulse_overcurrent_flag_o <= 1'b0;
      hiccup_overcurrent_flag_o <= 1'b0;
      zero_duty_flag_o <= 1'b0;
      ramp_low_voltage_flag_o <= 1'b0;
      fault_o <= 1'b0;
      pulse_sense_pulldown_o <= 1'b0;
      hiccup_sense_pulldown_o <= 1'b0;
    end
    else
    begin
      master_clock_out_o <= master_i && osc_s;
      sync_clock_o <= cyc_clk_w;
      pulse_sense_pulldown_o <= master_i && osc_s;
      hiccup_sense_pulldown_o <= master_i && osc_s;
      line_hyst_src_o <= !line_uv_s;
      // charge stops at the reference clamp
      ss_charge_o <= ss_d == acp_pkg::ACP_SS_START && !at_ref_s;
      ss_cc_discharge_o <= ss_d == acp_pkg::ACP_SS_STOP;
      ss_dump_o <= ss_d == acp_pkg::ACP_SS_DUMP;
      ramp_precharge_o <= lvp_d;
      ref_sel_softstart_o <= ss_low_s;
      pulse_overcurrent_flag_o <= poc_d;
      hiccup_overcurrent_flag_o <= hoc_s;
      zero_duty_flag_o <= zd_d;
      ramp_low_voltage_flag_o <= lvp_d;
      fault_o <= hard_w || soft_w;
    end
  end
  assign main_gate_o = gif.gate[acp_pkg::ACP_G_MAIN];
  assign clamp_gate_o = gif.gate[acp_pkg::ACP_G_CLAMP];
  assign forward_rect_gate_o = gif.gate[acp_pkg::ACP_G_FWD];
  assign freewheel_rect_gate_o = gif.gate[acp_pkg::ACP_G_FREE];

  a_hard_gates_low: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    hard_w |=> !main_gate_o && !clamp_gate_o && !forward_rect_gate_o && !freewheel_rect_gate_o)
    else $error("gates not low after hard fault");
  a_hard_dump: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    hard_w |=> ss_dump_o && !ss_charge_o)
    else $error("softstart not dumped on hard fault");
  // a hard fault in the following cycle takes over the gate pattern
  a_poc_freewheel: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (poc_s && !hard_w) ##1 !hard_w |=> freewheel_rect_gate_o && !main_gate_o)
    else $error("pulse overcurrent gate pattern wrong");
  a_poc_flag: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    poc_s |=> pulse_overcurrent_flag_o)
    else $error("pulse overcurrent flag not raised");
  a_latch_reset: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (pwm_s || maxd_s) |=> !latch_q)
    else $error("pwm latch not reset");
  a_zero_duty_block: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    zd_q |=> !latch_q)
    else $error("latch set while zero duty held");
  a_charge_clean: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    ss_charge_o |-> !$past(soft_w) && !$past(hard_w))
    else $error("softstart charging during fault");
  a_stop_latched: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (ss_q == acp_pkg::ACP_SS_STOP && !restart_s && !hard_w) |=> ss_q == acp_pkg::ACP_SS_STOP)
    else $error("soft-stop left before restart level");
  a_soft_enter: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (soft_w && !hard_w) |=> ss_q == acp_pkg::ACP_SS_STOP)
    else $error("soft fault did not enter soft-stop");
  a_lvp_set: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    lv_low_s |=> ramp_low_voltage_flag_o)
    else $error("ramp low-voltage flag not set");
  a_hyst_src: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    line_uv_s |=> !line_hyst_src_o)
    else $error("hysteresis current on during line undervolt");
  a_pulldown: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    1'b1 |=> pulse_sense_pulldown_o == master_clock_out_o
      && hiccup_sense_pulldown_o == master_clock_out_o)
    else $error("pull-down not tied to clock output");
endmodule : acp_ctrl

/* File: acp_partner.sv */
// far side model: a master controller feeding this block's sync input
`timescale 1ns/100ps
module acp_partner #(
  parameter int HALF = 7
) (
  input wire logic sys_clk_i,
  input wire logic run_i,
  output logic sync_o,
  output int rises_o
);
  int cnt = 0;
  initial sync_o = 1'b0;
  initial rises_o = 0;
  // clock stands low between bursts, as a stopped master would leave it
  always @(posedge sys_clk_i)
  begin
    #5;
    if (!run_i)
    begin
      cnt = 0;
      sync_o = 1'b0;
    end
    else if (cnt == HALF - 1)
    begin
      cnt = 0;
      sync_o = !sync_o;
      if (sync_o)
        rises_o = rises_o + 1;
    end
    else
      cnt = cnt + 1;
  end
endmodule : acp_partner

/* File: acp_ctrl_tb.sv */
// self-checking bench for the active clamp control block
`timescale 1ns/100ps
module acp_ctrl_tb;
  typedef struct packed {
    logic [6:0] flt;
    logic sw_chk;
    logic sw;
    logic chg;
    logic ccd;
    logic dump;
    logic hyst;
  } acp_row_t;
  logic sys_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [6:0] flt = 7'h00;
  logic ramp_hi = 1'b0, poc = 1'b0, zd_hi = 1'b0, zd_lo = 1'b0, restart = 1'b1;
  logic below_fb = 1'b0, osc = 1'b0, maxd = 1'b0, master = 1'b1, run = 1'b0, prev;
  logic pwm = 1'b0, at_ref = 1'b0;
  logic [31:0] dt_on = 32'h02020202;
  logic [31:0] dt_off = 32'h02020202;
  logic [18:0] outs;
  logic sync_s;
  int sync_rises, seen, base, fails = 0, comparisons = 0, hi_cnt, ph = 0, i;
  acp_row_t rows [8];
  always #25 sys_clk_i = ~sys_clk_i;
  // internal oscillator stand-in: 20 cycle period, max duty reset late in it
  always @(posedge sys_clk_i)
  begin
    #5;
    ph = (ph == 19) ? 0 : ph + 1;
    osc = (ph < 5);
    maxd = (ph >= 13);
  end
  acp_ctrl u_acp_ctrl (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .vref_uv_raw_i(flt[6]),
    .supply_uv_raw_i(flt[5]), .line_uv_raw_i(flt[4]), .thermal_shutdown_flag_i(flt[3]),
    .ramp_lv_low_i(flt[2]), .ramp_lv_high_i(ramp_hi), .res_open_i(flt[1]),
    .pulse_oc_cmp_i(poc), .hiccup_oc_cmp_i(flt[0]), .pwm_cmp_i(pwm), .zero_duty_hi_i(zd_hi),
    .zero_duty_lo_i(zd_lo), .ss_restart_i(restart), .ss_at_ref_i(at_ref),
    .ss_below_fb_i(below_fb), .osc_clk_i(osc), .maxduty_i(maxd), .sync_i(sync_s),
    .master_i(master), .dt_on_i(dt_on), .dt_off_i(dt_off), .main_gate_o(outs[18]),
    .clamp_gate_o(outs[17]), .forward_rect_gate_o(outs[16]),
    .freewheel_rect_gate_o(outs[15]), .master_clock_out_o(outs[14]),
    .sync_clock_o(outs[13]), .pulse_sense_pulldown_o(outs[12]),
    .hiccup_sense_pulldown_o(outs[11]), .line_hyst_src_o(outs[10]), .ss_charge_o(outs[9]),
    .ss_cc_discharge_o(outs[8]), .ss_dump_o(outs[7]), .ramp_precharge_o(outs[6]),
    .ref_sel_softstart_o(outs[5]), .pulse_overcurrent_flag_o(outs[4]),
    .hiccup_overcurrent_flag_o(outs[3]), .zero_duty_flag_o(outs[2]),
    .ramp_low_voltage_flag_o(outs[1]), .fault_o(outs[0]));
  acp_partner u_acp_partner (.sys_clk_i(sys_clk_i), .run_i(run), .sync_o(sync_s),
    .rises_o(sync_rises));
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
    #5;
  endtask : cyc
  task automatic chk(input string nm, input logic [31:0] seen_v, input logic [31:0] exp_v);
    comparisons++;
    if (seen_v !== exp_v)
    begin
      fails++;
      $display("BAD %s expected %0h seen %0h", nm, exp_v, seen_v);
    end
  endtask : chk
  task automatic count_hi(input int n, input int bit_no);
    hi_cnt = 0;
    repeat (n)
    begin
      cyc(1);
      if (outs[bit_no] === 1'b1)
        hi_cnt++;
    end
  endtask : count_hi
  // faults drop, ramp flag clears high, soft-stop released by restart level
  task automatic recover();
    flt = 7'h00;
    ramp_hi = 1'b1;
    restart = 1'b1;
    cyc(60);
    restart = 1'b0;
    ramp_hi = 1'b0;
    cyc(10);
  endtask : recover
  task automatic tally_and_finish();
    if (fails == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    repeat (20000) @(posedge sys_clk_i);
    fails++;
    tally_and_finish();
  end
  initial
  begin
    rows[0] = {7'h00, 6'b111001};
    rows[1] = {7'h40, 6'b100011};
    rows[2] = {7'h20, 6'b100011};
    rows[3] = {7'h10, 6'b000100};
    rows[4] = {7'h08, 6'b000101};
    rows[5] = {7'h04, 6'b100011};
    rows[6] = {7'h02, 6'b100011};
    rows[7] = {7'h01, 6'b000101};
    cyc(2);
    chk("reset outputs", 32'(outs), 32'h000A0);
    cyc(2);
    rst_b_i = 1'b1;
    recover();
    foreach (rows[k])
    begin
      flt = rows[k].flt;
      cyc(50);
      chk("ss charge", outs[9], rows[k].chg);
      chk("ss cc discharge", outs[8], rows[k].ccd);
      chk("ss dump", outs[7], rows[k].dump);
      chk("line hyst source", outs[10], rows[k].hyst);
      chk("ramp precharge", outs[6], rows[k].flt[2]);
      chk("ramp low flag", outs[1], rows[k].flt[2]);
      chk("hiccup flag", outs[3], rows[k].flt[0]);
      count_hi(40, 18);
      if (rows[k].sw_chk)
        chk("main switching", hi_cnt != 0, rows[k].sw);
      recover();
    end
    flt = 7'h20;
    cyc(20);
    flt = 7'h00;
    count_hi(60, 7);
    chk("short uv pulse", hi_cnt, 0);
    flt = 7'h01;
    cyc(10);
    flt = 7'h00;
    cyc(20);
    chk("soft stop held", outs[8], 1'b1);
    chk("no charge yet", outs[9], 1'b0);
    restart = 1'b1;
    cyc(8);
    chk("restart charge", outs[9], 1'b1);
    restart = 1'b0;
    i = 0;
    while (outs[18] !== 1'b1 && i < 100)
    begin
      cyc(1);
      i++;
    end
    poc = 1'b1;
    cyc(5);
    chk("pulse oc flag", outs[4], 1'b1);
    chk("pulse oc gates", outs[18:15], 4'b0001);
    poc = 1'b0;
    count_hi(60, 18);
    chk("next cycle resumes", hi_cnt != 0, 1'b1);
    repeat (40)
    begin
      cyc(1);
      chk("pulse pulldown", outs[12], outs[14]);
      chk("hiccup pulldown", outs[11], outs[14]);
    end
    count_hi(40, 14);
    chk("clock out duty", hi_cnt, 10);
    below_fb = 1'b1;
    cyc(6);
    chk("ref softstart", outs[5], 1'b1);
    below_fb = 1'b0;
    cyc(6);
    chk("ref feedback", outs[5], 1'b0);
    at_ref = 1'b1;
    cyc(6);
    chk("ss clamp", outs[9], 1'b0);
    at_ref = 1'b0;
    pwm = 1'b1;
    cyc(6);
    count_hi(40, 18);
    chk("pwm comparator reset", hi_cnt, 0);
    pwm = 1'b0;
    dt_on = 32'h02020205;
    dt_off = 32'h02020200;
    cyc(40);
    count_hi(40, 18);
    chk("main dead times", hi_cnt, 16);
    dt_on = 32'h02020202;
    dt_off = 32'h02020202;
    zd_hi = 1'b1;
    zd_lo = 1'b1;
    cyc(6);
    chk("zero duty set", outs[2], 1'b1);
    count_hi(40, 18);
    chk("zero duty no pulse", hi_cnt, 0);
    zd_lo = 1'b0;
    cyc(6);
    chk("zero duty held", outs[2], 1'b1);
    zd_hi = 1'b0;
    cyc(6);
    chk("zero duty clear", outs[2], 1'b0);
    zd_hi = 1'b1;
    cyc(6);
    chk("zero duty above low", outs[2], 1'b0);
    zd_hi = 1'b0;
    rst_b_i = 1'b0;
    cyc(2);
    chk("mid reset outputs", 32'(outs), 32'h000A0);
    rst_b_i = 1'b1;
    cyc(10);
    chk("restart after reset", outs[9], 1'b1);
    master = 1'b0;
    run = 1'b1;
    cyc(10);
    base = sync_rises;
    seen = 0;
    prev = outs[13];
    repeat (140)
    begin
      cyc(1);
      if (outs[13] === 1'b1 && prev === 1'b0)
        seen++;
      prev = outs[13];
    end
    chk("slave sync rises", (sync_rises - base - seen) inside {-1, 0, 1}, 1'b1);
    chk("slave clock out", outs[14], 1'b0);
    run = 1'b0;
    master = 1'b1;
    cyc(10);
    tally_and_finish();
  end
endmodule : acp_ctrl_tb
